// ==== pmc_pkg.sv ====
// constants, register map and state codes for the power mode control block
package pmc_pkg;
	// register indices (word index; byte address is four times the index)
	localparam logic [7:0]  PMC_SEL_IDX    = 8'hF5;    // power_mode_select, write only
	localparam logic [7:0]  PMC_STAT_IDX   = 8'hF6;    // mode and timer status, read only
	localparam logic [7:0]  PMC_DIV_IDX    = 8'hF7;    // interval_timer_clock_control
	localparam logic [9:0]  PMC_SEL_ADDR   = {PMC_SEL_IDX, 2'b00};
	localparam logic [9:0]  PMC_STAT_ADDR  = {PMC_STAT_IDX, 2'b00};
	localparam logic [9:0]  PMC_DIV_ADDR   = {PMC_DIV_IDX, 2'b00};
	// mode codes and reset values
	localparam logic [7:0]  PMC_CODE_STOP  = 8'h5A;    // arms stop
	localparam logic [7:0]  PMC_CODE_SLEEP = 8'h0F;    // enters sleep
	localparam logic [7:0]  PMC_SEL_RST    = 8'h00;    // select register reset value
	localparam logic [2:0]  PMC_DIV_RST    = 3'h7;     // timer divider reset value
	localparam logic [7:0]  PMC_BIT_FIRST  = 8'h00;    // stabilization count start
	localparam logic [7:0]  PMC_BIT_LAST   = 8'hFF;    // stabilization count end
	// status register field positions
	localparam int          PMC_STAT_CNT_LSB   = 0;
	localparam int          PMC_STAT_STATE_LSB = 8;
	localparam int          PMC_STAT_DIV_LSB   = 10;
	// power states
	typedef enum logic [1:0] {
		PMC_RUN   = 2'b00,
		PMC_SLEEP = 2'b01,
		PMC_STOP  = 2'b10,
		PMC_STAB  = 2'b11
	} pmc_state_e;
endpackage : pmc_pkg

// ==== pmc_bit_if.sv ====
// link between mode control and the basic interval timer
`timescale 1ns/1ps
interface pmc_bit_if;
	logic       start;     // restart count at zero
	logic       run;       // timer clock present
	logic [2:0] div_sel;   // prescaler division select
	logic [7:0] count;     // current timer count
	logic       ovf;       // count wrapped past its last value
	modport ctl (output start, output run, output div_sel, input count, input ovf);
	modport tmr (input start, input run, input div_sel, output count, output ovf);
endinterface : pmc_bit_if

// ==== pmc_bit_timer.sv ====
// basic interval timer with prescaler, used for wake-up stabilization
`timescale 1ns/1ps
module pmc_bit_timer
	import pmc_pkg::*;
(
	input  wire logic hclk,
	input  wire logic hresetn,
	pmc_bit_if.tmr    bt
);
	logic [7:0] pre;        // prescaler
	logic [7:0] next_pre;
	logic [7:0] cnt;        // timer count
	logic [7:0] next_cnt;
	logic       tick;       // one prescaled period done

	// prescaler tick: low div_sel bits all set
	function automatic logic pmc_tick(logic [7:0] p, logic [2:0] s);
		logic [7:0] m;
		m = (8'h01 << s) - 8'h01;
		return &(p | ~m);
	endfunction : pmc_tick

	// next prescaler and count
	always_comb begin
		tick     = pmc_tick(pre, bt.div_sel);
		next_pre = pre;
		next_cnt = cnt;
		if (bt.start) begin                  // restart from zero
			next_pre = 8'h00;
			next_cnt = PMC_BIT_FIRST;
		end else if (bt.run) begin            // frozen while clocks stop
			next_pre = tick ? 8'h00 : pre + 8'h01;
			if (tick)
				next_cnt = cnt + 8'h01;
		end
	end

	// register state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre <= 8'h00;
			cnt <= PMC_BIT_FIRST;
		end else begin
			pre <= next_pre;
			cnt <= next_cnt;
		end
	end

	assign bt.count = cnt;
	assign bt.ovf   = bt.run && !bt.start && tick && (cnt == PMC_BIT_LAST);

	AST_BIT_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
		bt.start |=> (cnt == PMC_BIT_FIRST))
		else $error("timer did not restart at zero");
endmodule : pmc_bit_timer

// ==== pmc_power_ctrl.sv ====
// power-down mode control: sleep, stop, wake-up and stabilization
// Summary of operation
// - writing 0Fh enters sleep, CPU halts
// - sleep keeps oscillator and peripherals running
// - sleep ends on reset or any interrupt
// - stop only on halt with 5Ah armed
// - leaving stop clears the select register
// - 8-bit write-only select, resets to zero
// - stop freezes oscillator, system, peripheral clocks
// - ports keep level and direction in stop
// - PC holds next address during stop
// - stop exits by reset, external interrupt, events
// - reset wake reinitializes controls, keeps RAM
// - interrupt wake keeps RAM and divider; stop wake clears select
// - flag set vectors, clear resumes after halt
// - wake waits for timer 00h to FFh overflow
// - stop halts timers except event counters
// - stabilization is one interval timer cycle
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pmc_power_ctrl
	import pmc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        halt_exec,
	input  wire logic        irq_any,
	input  wire logic        ext_irq,
	input  wire logic        event_count_input_a,
	input  wire logic        event_count_input_b,
	input  wire logic        global_int_flag,
	output logic             cpu_halt,
	output logic             pc_hold,
	output logic             clk_run,
	output logic             periph_run,
	output logic             event_counter_run,
	output logic             port_hold,
	output logic [1:0]       power_state,
	output logic             int_vector_take,
	output logic             exec_resume
);
	pmc_bit_if bt ();                   // timer link

	// register id decode, used for read and write paths
	typedef enum logic [1:0] {
		PMC_ID_NONE = 2'b00,
		PMC_ID_SEL  = 2'b01,
		PMC_ID_STAT = 2'b10,
		PMC_ID_DIV  = 2'b11
	} pmc_id_e;

	// one decoder feeds both the read mux and the write target,
	// so a register can never be read at one index and written at another
	function automatic pmc_id_e pmc_decode(logic [31:0] a);
		if (a[31:10] != 22'h0)
			return PMC_ID_NONE;
		unique case (1'b1)
			(a[9:2] == PMC_SEL_ADDR[9:2]):  return PMC_ID_SEL;
			(a[9:2] == PMC_STAT_ADDR[9:2]): return PMC_ID_STAT;
			(a[9:2] == PMC_DIV_ADDR[9:2]):  return PMC_ID_DIV;
			default:                        return PMC_ID_NONE;
		endcase
	endfunction : pmc_decode

	// bus state
	logic        wr_pend;          // write data phase pending
	logic        next_wr_pend;
	pmc_id_e     wr_id;            // target of pending write
	pmc_id_e     next_wr_id;
	logic [31:0] next_hrdata;
	logic        addr_ok;          // valid address phase

	// control registers
	logic [7:0]  mode_sel;         // power_mode_select
	logic [7:0]  next_mode_sel;
	logic [2:0]  div_sel;          // interval_timer_clock_control
	logic [2:0]  next_div_sel;

	// mode state
	pmc_state_e  state;
	pmc_state_e  next_state;
	logic        wake_int;         // woke by interrupt, not reset
	logic        next_wake_int;
	logic        next_vec;
	logic        next_resume;
	logic        ev_a_q;           // event pin history
	logic        ev_b_q;
	logic        ev_edge;          // rising event on either counter
	logic        stop_wake;
	logic        sel_write;        // write to select register this cycle
	logic        sleep_go;
	logic        stop_go;

	// bus answers at once, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_ok   = hsel && hready && htrans[1];

	// bus: capture address phase and build read data
	// read data is formed in the address phase and registered, so it
	// stands through the whole data phase with no wait state
	always_comb begin
		next_wr_pend = addr_ok && hwrite;
		next_wr_id   = addr_ok ? pmc_decode(haddr) : PMC_ID_NONE;
		next_hrdata  = 32'h0000_0000;
		if (addr_ok && !hwrite) begin
			unique case (pmc_decode(haddr))
				PMC_ID_STAT: begin         // live state and count
					next_hrdata[PMC_STAT_CNT_LSB +: 8]   = bt.count;
					next_hrdata[PMC_STAT_STATE_LSB +: 2] = state;
					next_hrdata[PMC_STAT_DIV_LSB +: 3]   = div_sel;
				end
				PMC_ID_DIV:  next_hrdata[2:0] = div_sel;
				PMC_ID_SEL:  next_hrdata = 32'h0000_0000;  // write only reads zero
				PMC_ID_NONE: next_hrdata = 32'h0000_0000;  // unmapped reads zero
			endcase
		end
	end

	// register bus state and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_id   <= PMC_ID_NONE;
			hrdata  <= 32'h0000_0000;
		end else begin
			wr_pend <= next_wr_pend;
			wr_id   <= next_wr_id;
			hrdata  <= next_hrdata;
		end
	end

	// entry and wake conditions
	// stop outranks sleep when an armed halt and a sleep write meet
	// event pins are sampled every cycle, so a rise during stop is seen
	assign sel_write = wr_pend && (wr_id == PMC_ID_SEL);
	assign sleep_go  = sel_write && (hwdata[7:0] == PMC_CODE_SLEEP) && (state == PMC_RUN);
	assign stop_go   = halt_exec && (mode_sel == PMC_CODE_STOP) && (state == PMC_RUN);
	assign ev_edge   = (event_count_input_a && !ev_a_q) || (event_count_input_b && !ev_b_q);
	assign stop_wake = ext_irq || ev_edge;

	// next control registers and mode state
	// a write during sleep or stop still lands, except a select write in the stop wake cycle, which the clear overrides; it changes no mode
	always_comb begin
		next_mode_sel = mode_sel;
		next_div_sel  = div_sel;
		next_state    = state;
		next_wake_int = wake_int;
		next_vec      = 1'b0;
		next_resume   = 1'b0;
		if (sel_write)
			next_mode_sel = hwdata[7:0];
		if (wr_pend && (wr_id == PMC_ID_DIV))
			next_div_sel = hwdata[2:0];
		unique case (state)
			PMC_RUN: begin
				if (stop_go)
					next_state = PMC_STOP;
				else if (sleep_go)
					next_state = PMC_SLEEP;
			end
			PMC_SLEEP: begin
				if (irq_any) begin
					next_state    = PMC_STAB;
					next_wake_int = 1'b1;
				end
			end
			PMC_STOP: begin
				if (stop_wake) begin
					next_state    = PMC_STAB;
					next_wake_int = 1'b1;
					// cleared so a later halt without a fresh arm is inert
					next_mode_sel = PMC_SEL_RST;
				end
			end
			PMC_STAB: begin
				if (bt.ovf) begin
					next_state    = PMC_RUN;
					next_wake_int = 1'b0;
					next_vec      = wake_int && global_int_flag;
					next_resume   = wake_int && !global_int_flag;
				end
			end
		endcase
	end

	// reset lands in stabilization with controls at reset values
	// a reset wake ends without a vector or resume pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_sel        <= PMC_SEL_RST;
			div_sel         <= PMC_DIV_RST;
			state           <= PMC_STAB;
			wake_int        <= 1'b0;
			int_vector_take <= 1'b0;
			exec_resume     <= 1'b0;
			ev_a_q          <= 1'b0;
			ev_b_q          <= 1'b0;
		end else begin
			mode_sel        <= next_mode_sel;
			div_sel         <= next_div_sel;
			state           <= next_state;
			wake_int        <= next_wake_int;
			int_vector_take <= next_vec;
			exec_resume     <= next_resume;
			ev_a_q          <= event_count_input_a;
			ev_b_q          <= event_count_input_b;
		end
	end

	// timer: restarts at wake, frozen in stop
	// restart only on the entering edge so the count is not pinned at zero
	assign bt.start   = (state != PMC_STAB) && (next_state == PMC_STAB);
	assign bt.run     = (state != PMC_STOP);
	assign bt.div_sel = div_sel;

	pmc_bit_timer u_bit (
		.hclk    (hclk),
		.hresetn (hresetn),
		.bt      (bt.tmr)
	);

	// power outputs decoded from the state register
	// decoded from a flip-flop state, so the clock enables never glitch
	assign cpu_halt          = (state != PMC_RUN);
	assign pc_hold           = (state == PMC_STOP) || (state == PMC_SLEEP);
	assign clk_run           = (state != PMC_STOP);
	assign periph_run        = (state != PMC_STOP);
	assign event_counter_run = 1'b1;
	assign port_hold         = (state == PMC_STOP);
	assign power_state       = state;

	// checks, all on the bus clock and off during reset
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_stop_enter;
		(state == PMC_RUN) && halt_exec && (mode_sel == PMC_CODE_STOP);
	endsequence
	sequence s_stop_leave;
		(state == PMC_STOP) && stop_wake;
	endsequence
	// stabilization ending after a reset, not after a wake
	sequence s_reset_done;
		(state == PMC_STAB) && bt.ovf && !wake_int;
	endsequence

	AST_SLEEP_ENTRY: assert property (sleep_go && !halt_exec |=>
		(state == PMC_SLEEP) && cpu_halt && clk_run)
		else $error("sleep not entered after 0Fh write");
	AST_STOP_ENTRY: assert property (s_stop_enter |=>
		(state == PMC_STOP) && !clk_run && port_hold)
		else $error("stop not entered on armed halt");
	AST_STOP_NEEDS_ARM: assert property ((state == PMC_RUN) && halt_exec &&
		(mode_sel != PMC_CODE_STOP) |=> (state != PMC_STOP))
		else $error("stop entered without 5Ah");
	AST_STOP_CLEAR: assert property (s_stop_leave |=>
		(mode_sel == PMC_SEL_RST) && (state == PMC_STAB))
		else $error("select not cleared on stop exit");
	AST_OTHER_CODE: assert property ((state == PMC_RUN) && sel_write && !halt_exec &&
		(hwdata[7:0] != PMC_CODE_SLEEP) |=> (state == PMC_RUN))
		else $error("undefined code changed mode");
	AST_STOP_HOLD: assert property ((state == PMC_STOP) && !stop_wake |=>
		(state == PMC_STOP) && $stable(bt.count) && pc_hold)
		else $error("stop left without source");
	AST_SLEEP_WAKE: assert property ((state == PMC_SLEEP) && irq_any |=>
		(state == PMC_STAB) && (bt.count == PMC_BIT_FIRST))
		else $error("sleep not released by interrupt");
	AST_STAB_WAIT: assert property ((state == PMC_STAB) && !bt.ovf |=>
		(state == PMC_STAB) && cpu_halt)
		else $error("run before timer overflow");
	AST_VECTOR: assert property ((state == PMC_STAB) && bt.ovf && wake_int &&
		global_int_flag |=> int_vector_take && !exec_resume ##1 !int_vector_take)
		else $error("interrupt vector not taken");
	AST_RESUME: assert property ((state == PMC_STAB) && bt.ovf && wake_int &&
		!global_int_flag |=> exec_resume && !int_vector_take && (state == PMC_RUN))
		else $error("no resume after wake");
	// sleep keeps every clock and the timer running
	AST_SLEEP_RUNS: assert property ((state == PMC_SLEEP) |->
		clk_run && periph_run && bt.run && !port_hold)
		else $error("clock stopped in sleep");
	// stop freezes clocks and timer, event counters stay live
	AST_STOP_FREEZE: assert property ((state == PMC_STOP) |->
		!clk_run && !periph_run && !bt.run && event_counter_run)
		else $error("clock running in stop");
	// reset wake runs without a vector or resume
	AST_RESET_QUIET: assert property (s_reset_done |=>
		(state == PMC_RUN) && !int_vector_take && !exec_resume)
		else $error("pulse after reset stabilization");
endmodule : pmc_power_ctrl

// ==== power_down_mode_control_tb_top.sv ====
// self-checking testbench for the power mode control block
`timescale 1ns/1ps
module power_down_mode_control_tb_top
	import pmc_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, halt_exec;   // clock, reset, bus and cpu
	logic        irq_any, ext_irq, ev_a, ev_b, gflag;      // wake sources and flag
	logic [31:0] haddr, hwdata;                            // bus address and data
	logic [1:0]  htrans;                                   // transfer kind
	logic [2:0]  hsize;                                    // transfer size
	logic        hreadyout, hresp, cpu_halt, pc_hold;      // design outputs
	logic        clk_run, periph_run, ev_run, port_hold;   // clock and port controls
	logic        ivt, resume;                              // wake pulses
	logic [31:0] hrdata;                                   // read data
	logic [1:0]  power_state;                              // state register
	logic [31:0] exp_rd[$];                                // read data notes
	logic [1:0]  exp_pl[$];                                // wake pulse notes
	logic        rd_dphase;                                // read data phase marker
	int          errors, n_checks;                         // counters

	pmc_power_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.halt_exec(halt_exec), .irq_any(irq_any), .ext_irq(ext_irq),
		.event_count_input_a(ev_a), .event_count_input_b(ev_b), .global_int_flag(gflag),
		.cpu_halt(cpu_halt), .pc_hold(pc_hold), .clk_run(clk_run), .periph_run(periph_run),
		.event_counter_run(ev_run), .port_hold(port_hold), .power_state(power_state),
		.int_vector_take(ivt), .exec_resume(resume));

	// clock generator, 10 ns period
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// closing report and verdict
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// watchdog against hangs
	initial begin
		repeat (20000) @(posedge hclk);
		errors++;
		print_verdict();
	end

	// output watcher, takes the oldest note per result at the closing edge
	always @(posedge hclk) begin
		if (rd_dphase === 1'b1) begin
			check("okay response", hresp, 0);
			if (exp_rd.size() == 0) check("read without note", 1, 0);
			else check("read data", hrdata, exp_rd.pop_front());
		end
		if (ivt === 1'b1 || resume === 1'b1) begin
			if (exp_pl.size() == 0) check("unexpected wake pulse", 1, 0);
			else check("wake pulse", {ivt, resume}, exp_pl.pop_front());
		end
	end

	// one single transfer, address then data phase
	task automatic ahb(input logic wr, input logic [9:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {22'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		rd_dphase <= !wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_dphase <= 1'b0;
	endtask : ahb

	// read with a noted expectation
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		ahb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// bounded wait for a power state
	task automatic wait_state(input logic [1:0] s, input int lim);
		for (int i = 0; i < lim && power_state !== s; i++) begin
			@(posedge hclk);
			#1;
		end
		check("power state", power_state, s);
	endtask : wait_state

	// one cycle halt instruction
	task automatic halt_pulse();
		halt_exec <= 1'b1;
		@(posedge hclk);
		halt_exec <= 1'b0;
		repeat (3) @(posedge hclk);
		#1;
	endtask : halt_pulse

	// stabilization length and the resulting pulse
	task automatic finish_wake();
		int n;
		n = 0;
		exp_pl.push_back(gflag ? 2'b10 : 2'b01);
		while (power_state === PMC_STAB && n < 2000) begin
			@(posedge hclk);
			#1;
			n++;
		end
		// one full timer cycle, 256 ticks of one clock with the divider at zero
		check("stab cycles", n, 256);
		check("run after stab", power_state, PMC_RUN);
		check("cpu runs after stab", cpu_halt, 0);
		check("ports released", port_hold, 0);
		check("clock back after stab", clk_run, 1);
		repeat (2) @(posedge hclk);
		check("wake pulse seen", exp_pl.size(), 0);
	endtask : finish_wake

	// main sequence
	initial begin
		logic [7:0] v;
		{hsel, hwrite, halt_exec, irq_any, ext_irq, ev_a, ev_b, gflag, rd_dphase} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		hresetn = 1'b0;
		errors = 0;
		n_checks = 0;
		void'($urandom(32'h2aaf));
		for (int r = 0; r < 2; r++) begin
			hresetn <= 1'b0;
			repeat (8) @(posedge hclk);
			hresetn <= 1'b1;
			@(posedge hclk);
			#1;
			check("state after reset", power_state, PMC_STAB);
			rd(PMC_DIV_ADDR, 32'h0000_0007);
			rd(PMC_SEL_ADDR, 32'h0000_0000);
			// stab state, divider seven, count still at its first value
			rd(PMC_STAT_ADDR, 32'h0000_1F00);
			// divider set before any halt; a short count keeps the run brief
			ahb(1'b1, PMC_DIV_ADDR, r ? 32'h0000_0000 : 32'h0000_0003);
		end
		ahb(1'b1, 10'h3E0, $urandom);
		rd(10'h3E0, 32'h0000_0000);
		wait_state(PMC_RUN, 600);
		// sleep entry and interrupt release
		ahb(1'b1, PMC_SEL_ADDR, {24'h00_0000, PMC_CODE_SLEEP});
		wait_state(PMC_SLEEP, 3);
		repeat (5) @(posedge hclk);
		#1;
		check("sleep holds", power_state, PMC_SLEEP);
		check("cpu halted", cpu_halt, 1);
		check("pc held in sleep", pc_hold, 1);
		check("clock runs in sleep", clk_run, 1);
		check("periph runs in sleep", periph_run, 1);
		gflag <= 1'(($urandom));
		irq_any <= 1'b1;
		wait_state(PMC_STAB, 3);
		irq_any <= 1'b0;
		finish_wake();
		// stop entry and release by external interrupt, event pin a and event pin b
		for (int k = 0; k < 3; k++) begin
			ahb(1'b1, PMC_SEL_ADDR, {24'h00_0000, PMC_CODE_STOP});
			halt_pulse();
			check("stop entered", power_state, PMC_STOP);
			check("clock stopped", clk_run, 0);
			check("periph stopped", periph_run, 0);
			check("ports held", port_hold, 1);
			check("pc held", pc_hold, 1);
			check("event counters run", ev_run, 1);
			irq_any <= 1'b1;
			repeat (4) @(posedge hclk);
			#1;
			check("other irq ignored in stop", power_state, PMC_STOP);
			irq_any <= 1'b0;
			gflag <= 1'(($urandom));
			if (k == 0) ext_irq <= 1'b1;
			else if (k == 1) ev_a <= 1'b1;
			else ev_b <= 1'b1;
			wait_state(PMC_STAB, 3);
			{ext_irq, ev_a, ev_b} <= 3'b000;
			finish_wake();
			rd(PMC_DIV_ADDR, 32'h0000_0000);
			halt_pulse();
			check("select cleared by stop exit", power_state, PMC_RUN);
		end
		// undefined codes do nothing
		do v = 8'($urandom); while (v == PMC_CODE_STOP || v == PMC_CODE_SLEEP);
		ahb(1'b1, PMC_SEL_ADDR, {24'h00_0000, v});
		halt_pulse();
		check("other code ignored", power_state, PMC_RUN);
		print_verdict();
	end
endmodule : power_down_mode_control_tb_top
